// File: rtl/osp_axis.sv
// Origin search sequencer, origin latch and present position preset for one axis.
// Assumes drive feedback and tool signals on i_clk_sys; sensor pins are asynchronous.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module osp_axis
  import osp_pkg::*;
#(
  parameter int DWELL_CYCLES = DWELL_CYC,
  parameter int DEVR_CYCLES  = DEVR_CYC
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,
  input  wire logic [AW-1:0]       i_addr,
  input  wire logic [DW-1:0]       i_wdata,
  input  wire logic                i_we,
  input  wire logic                i_re,
  output logic      [DW-1:0]       o_rdata,
  input  wire logic                i_prox,
  input  wire logic                i_origin,
  input  wire logic                i_intr,
  input  wire logic signed [15:0]  i_pos_delta,
  input  wire logic                i_drive_busy,
  input  wire logic                i_stop,
  input  wire logic                i_tool_mode,
  input  wire logic                i_tool_other_busy,
  output osp_drive_s               o_drive,
  output logic                     o_start,
  output osp_stat_s                o_stat
);
  // The fix state lasts one cycle so the offset lands after any compensation move
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_REV   = 3'b001,
    S_SRCH  = 3'b010,
    S_APPR  = 3'b011,
    S_DEVR  = 3'b100,
    S_DWELL = 3'b101,
    S_COMP  = 3'b110,
    S_FIX   = 3'b111
  } osp_st_e;

  // Magnitude of a two's complement word; the most negative value maps to itself
  function automatic logic [DW-1:0] osp_abs(input logic [DW-1:0] v);
    return v[DW-1] ? (~v + 32'h1) : v;
  endfunction

  // Setup registers written by the host
  logic [DW-1:0] ctrl_r;
  logic [DW-1:0] offs_r;
  logic [DW-1:0] comp_r;
  logic [DW-1:0] mask_r;
  logic [DW-1:0] decel_r;
  logic [DW-1:0] rotmax_r;
  logic [DW-1:0] pval_r;
  // Motion and position state
  logic [DW-1:0] pos_r;
  logic [DW-1:0] pos_nxt;
  logic [DW-1:0] latch_r;
  logic [DW-1:0] trav_r;
  logic [DW-1:0] trav_nxt;
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  logic [7:0]    err_r;
  logic [7:0]    err_nxt;
  logic          def_r;
  logic          def_nxt;
  osp_st_e       st_r;
  osp_st_e       st_nxt;
  // Pin stages: bit 0 proximity, bit 1 origin, bit 2 interrupt feed
  logic [2:0]    sy1_r;
  logic [2:0]    sy2_r;
  logic [2:0]    sy3_r;
  logic [2:0]    filt_r;
  logic [2:0]    filt_d_r;
  logic [2:0]    filt_nxt;

  // Three-stage pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1_r    <= 3'h0;
      sy2_r    <= 3'h0;
      sy3_r    <= 3'h0;
      filt_r   <= 3'h0;
      filt_d_r <= 3'h0;
    end else begin
      sy1_r    <= {i_intr, i_origin, i_prox};
      sy2_r    <= sy1_r;
      sy3_r    <= sy2_r;
      filt_r   <= filt_nxt;
      filt_d_r <= filt_r;
    end
  end
  assign filt_nxt = (sy2_r & sy3_r) | (filt_r & (sy2_r | sy3_r));

  // Edge flags last one cycle after the filtered level rises
  wire prox_f    = filt_r[0];
  wire prox_rise = filt_r[0] & ~filt_d_r[0];
  wire org_rise  = filt_r[1] & ~filt_d_r[1];
  wire intr_rise = filt_r[2] & ~filt_d_r[2];

  wire [3:0] mode    = ctrl_r[CTL_MODE_LSB +: CTL_MODE_W];
  wire       det_dir = ctrl_r[CTL_DIR];
  wire       clr_en  = ctrl_r[CTL_CLR_EN];
  wire       inf_rot = ctrl_r[CTL_INF_ROT];
  wire       devr_en = ctrl_r[CTL_DEVR_EN];

  wire          wr_cmd = i_we & (i_addr == REG_CMD);
  wire [DW-1:0] cmd    = wr_cmd ? i_wdata : 32'h0;
  wire          busy   = o_stat.busy;
  wire          err_on = (err_r != ERR_NONE);

  wire any_start = cmd[CMD_DIRECT] | cmd[CMD_MULTI] | cmd[CMD_MSTART] | cmd[CMD_MINDIV]
                 | cmd[CMD_CHAIN] | cmd[CMD_JOG] | intr_rise;
  wire motion_req = cmd[CMD_HOME] | any_start;
  // Tool mode serialises the axes; a refused command raises an error instead
  wire tool_rej   = i_tool_mode & i_tool_other_busy & motion_req;
  wire go_ok      = ~err_on & ~tool_rej;

  // Homing start and its refusals
  wire home_req  = cmd[CMD_HOME] & go_ok & ~busy;
  wire mode_sup  = (mode == MODE_PROX) | (mode == MODE_NOPRX) | (mode == MODE_PRSET);
  wire mask_bad  = home_req & (mode == MODE_MASK) & (mask_r < decel_r);
  wire mode_bad  = home_req & ~mode_sup & ~mask_bad;
  wire home_go   = home_req & mode_sup;
  wire home_pre  = home_go & (mode == MODE_PRSET);

  // Present position preset: no travel limit check; only the infinite rotation range is checked
  wire pre_req   = cmd[CMD_PRESET] & ~err_on;
  wire pre_busy  = pre_req & busy;
  wire rot_bad   = pre_req & inf_rot & (pval_r[DW-1] | (pval_r > rotmax_r));
  wire pre_ok    = pre_req & ~pre_busy & ~rot_bad;

  // Start-clear: only positioning starts, never chained steps, jog or origin return
  wire clr_ev = cmd[CMD_DIRECT] | cmd[CMD_MULTI] | intr_rise
              | cmd[CMD_MSTART] | cmd[CMD_MINDIV];
  wire st_clr = clr_en & clr_ev & go_ok;
  wire start_ok = any_start & go_ok;

  wire          comp_nz  = (comp_r != 32'h0);
  wire [DW-1:0] comp_abs = osp_abs(comp_r);
  wire [DW-1:0] delta_x  = {{16{i_pos_delta[15]}}, i_pos_delta};
  wire [DW-1:0] dcnt_ld  = DEVR_CYCLES[DW-1:0];
  wire [DW-1:0] dwel_ld  = DWELL_CYCLES[DW-1:0];
  wire          cnt_zero = (cnt_r == 32'h0);

  // Counters stop at zero so a stale count cannot wrap into a long wait
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_zero ? cnt_r : cnt_r - 32'h1;
    trav_nxt = trav_r;
    unique case (st_r)
      S_IDLE: begin
        if (home_go && mode == MODE_PROX) begin
          st_nxt = prox_f ? S_REV : S_SRCH;
        end else if (home_go && mode == MODE_NOPRX) begin
          st_nxt = S_APPR;
        end
      end
      S_REV: begin
        if (!prox_f) begin
          st_nxt = S_APPR;
        end
      end
      S_SRCH: begin
        if (prox_rise) begin
          st_nxt = S_APPR;
        end
      end
      S_APPR: begin
        if (org_rise) begin
          trav_nxt = 32'h0;
          if (!comp_nz) begin
            st_nxt = S_FIX;
          end else if (devr_en) begin
            st_nxt  = S_DEVR;
            cnt_nxt = dcnt_ld;
          end else begin
            st_nxt = S_COMP;
          end
        end
      end
      S_DEVR: begin
        if (cnt_zero) begin
          st_nxt  = S_DWELL;
          cnt_nxt = dwel_ld;
        end
      end
      S_DWELL: begin
        if (cnt_zero) begin
          st_nxt = S_COMP;
        end
      end
      S_COMP: begin
        trav_nxt = trav_r + osp_abs(delta_x);
        if (trav_nxt >= comp_abs) begin
          st_nxt = S_FIX;
        end
      end
      S_FIX: begin
        st_nxt = S_IDLE;
      end
    endcase
    // A deceleration stop abandons the search with the origin left undefined
    if (i_stop && st_r != S_IDLE) begin
      st_nxt = S_IDLE;
    end
  end

  // Origin is fixed at the offset only after any compensation move has finished
  wire fix_now = (st_r == S_FIX);
  assign pos_nxt = (home_pre | fix_now) ? offs_r
                 : pre_ok ? pval_r
                 : st_clr ? 32'h0
                 : pos_r + delta_x;
  assign def_nxt = (home_pre | fix_now | pre_ok) ? 1'b1
                 : (home_go | st_clr) ? 1'b0
                 : def_r;

  // While an error stands, new ones are not recorded and only the clear acts;
  // the host must clear before a refused command can report again
  assign err_nxt = err_on ? (cmd[CMD_ERRCLR] ? ERR_NONE : err_r)
                 : tool_rej ? ERR_TOOL
                 : mask_bad ? ERR_MASKA
                 : mode_bad ? ERR_MODE
                 : pre_busy ? ERR_PBUSY
                 : rot_bad ? ERR_ROT
                 : ERR_NONE;

  // Drive commands follow the next state so drive and sequencer move together
  wire        runs = (st_nxt == S_REV) | (st_nxt == S_SRCH) | (st_nxt == S_APPR)
                   | (st_nxt == S_COMP);
  // Torque limit is driven straight from here; the host must have mapped its data
  osp_drive_s drv_nxt;
  assign drv_nxt.run        = runs;
  assign drv_nxt.dir        = (st_nxt == S_REV) ? ~det_dir
                            : (st_nxt == S_COMP) ? ~comp_r[DW-1] : det_dir;
  assign drv_nxt.speed      = (st_nxt == S_REV || st_nxt == S_SRCH) ? SPD_SEARCH
                            : (st_nxt == S_APPR) ? SPD_APPR
                            : (st_nxt == S_COMP) ? SPD_COMP : SPD_STOP;
  assign drv_nxt.torque_lim = (st_nxt == S_APPR);
  assign drv_nxt.dev_reset  = (st_nxt == S_DEVR);

  wire [DW-1:0] stat_w = {27'h0, o_drive.torque_lim, err_on, busy, o_stat.at_origin, def_r};
  // Command and unmapped indices read as zero
  wire [DW-1:0] rd_val = (i_addr == REG_CTRL)   ? ctrl_r
                       : (i_addr == REG_OFFS)   ? offs_r
                       : (i_addr == REG_COMP)   ? comp_r
                       : (i_addr == REG_MASK)   ? mask_r
                       : (i_addr == REG_DECEL)  ? decel_r
                       : (i_addr == REG_ROTMAX) ? rotmax_r
                       : (i_addr == REG_PVAL)   ? pval_r
                       : (i_addr == REG_STAT)   ? stat_w
                       : (i_addr == REG_POS)    ? pos_r
                       : (i_addr == REG_LATCH)  ? latch_r
                       : (i_addr == REG_ERR)    ? {24'h0, err_r}
                       : 32'h0;

  // Setup registers; status, position, latch and error ignore writes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r   <= CTRL_RST;
      offs_r   <= 32'h0;
      comp_r   <= 32'h0;
      mask_r   <= 32'h0;
      decel_r  <= 32'h0;
      rotmax_r <= 32'h0;
      pval_r   <= 32'h0;
    end else if (i_we) begin
      ctrl_r   <= (i_addr == REG_CTRL)   ? i_wdata : ctrl_r;
      offs_r   <= (i_addr == REG_OFFS)   ? i_wdata : offs_r;
      comp_r   <= (i_addr == REG_COMP)   ? i_wdata : comp_r;
      mask_r   <= (i_addr == REG_MASK)   ? i_wdata : mask_r;
      decel_r  <= (i_addr == REG_DECEL)  ? i_wdata : decel_r;
      rotmax_r <= (i_addr == REG_ROTMAX) ? i_wdata : rotmax_r;
      pval_r   <= (i_addr == REG_PVAL)   ? i_wdata : pval_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r    <= S_IDLE;
      cnt_r   <= 32'h0;
      trav_r  <= 32'h0;
      pos_r   <= 32'h0;
      def_r   <= 1'b0;
      err_r   <= ERR_NONE;
      latch_r <= 32'h0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      trav_r  <= trav_nxt;
      pos_r   <= pos_nxt;
      def_r   <= def_nxt;
      err_r   <= err_nxt;
      // Latch takes the position before this cycle's feedback is added
      latch_r <= (st_r == S_APPR && org_rise) ? pos_r : latch_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
      o_drive <= '0;
      o_start <= 1'b0;
      o_stat  <= '0;
    end else begin
      o_rdata           <= i_re ? rd_val : 32'h0;
      o_drive           <= drv_nxt;
      o_start           <= start_ok;
      // Status uses next values so it lines up with the position it reports
      o_stat.origin_def <= def_nxt;
      o_stat.at_origin  <= def_nxt & (pos_nxt == 32'h0);
      o_stat.busy       <= (st_nxt != S_IDLE) | i_drive_busy;
      o_stat.error      <= (err_nxt != ERR_NONE);
    end
  end
endmodule
`default_nettype wire

// File: rtl/osp_pkg.sv
// Constants, register map and carrier types for the origin search and preset block.
// Assumes one 100 MHz system clock and a word-addressed plain register port.
package osp_pkg;
  localparam int AW = 4;
  localparam int DW = 32;

  localparam logic [AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AW-1:0] REG_OFFS   = 4'h1;
  localparam logic [AW-1:0] REG_COMP   = 4'h2;
  localparam logic [AW-1:0] REG_MASK   = 4'h3;
  localparam logic [AW-1:0] REG_DECEL  = 4'h4;
  localparam logic [AW-1:0] REG_ROTMAX = 4'h5;
  localparam logic [AW-1:0] REG_PVAL   = 4'h6;
  localparam logic [AW-1:0] REG_CMD    = 4'h7;
  localparam logic [AW-1:0] REG_STAT   = 4'h8;
  localparam logic [AW-1:0] REG_POS    = 4'h9;
  localparam logic [AW-1:0] REG_LATCH  = 4'ha;
  localparam logic [AW-1:0] REG_ERR    = 4'hb;

  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_MODE_W   = 4;
  localparam int CTL_DIR      = 4;
  localparam int CTL_CLR_EN   = 5;
  localparam int CTL_INF_ROT  = 6;
  localparam int CTL_DEVR_EN  = 7;
  localparam logic [DW-1:0] CTRL_RST = 32'h0000_000d;

  // Command register bits, write-only pulses
  localparam int CMD_HOME   = 0;
  localparam int CMD_PRESET = 1;
  localparam int CMD_DIRECT = 2;
  localparam int CMD_MULTI  = 3;
  localparam int CMD_MSTART = 4;
  localparam int CMD_MINDIV = 5;
  localparam int CMD_CHAIN  = 6;
  localparam int CMD_JOG    = 7;
  localparam int CMD_ERRCLR = 8;

  // Status register bits
  localparam int ST_DEF  = 0;
  localparam int ST_ATOR = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_ERR  = 3;
  localparam int ST_TRQ  = 4;

  localparam logic [3:0] MODE_MASK  = 4'h9;
  localparam logic [3:0] MODE_PROX  = 4'hc;
  localparam logic [3:0] MODE_NOPRX = 4'hd;
  localparam logic [3:0] MODE_PRSET = 4'he;

  localparam logic [7:0] ERR_NONE  = 8'h00;
  localparam logic [7:0] ERR_PBUSY = 8'h01;
  localparam logic [7:0] ERR_ROT   = 8'h02;
  localparam logic [7:0] ERR_MASKA = 8'h03;
  localparam logic [7:0] ERR_MODE  = 8'h04;
  localparam logic [7:0] ERR_TOOL  = 8'h05;

  localparam int CLK_KHZ  = 100_000;
  localparam int DWELL_MS = 500;
  localparam int DEVR_MS  = 10;
  localparam int DWELL_CYC = DWELL_MS * CLK_KHZ;
  localparam int DEVR_CYC  = DEVR_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    SPD_STOP   = 2'b00,
    SPD_SEARCH = 2'b01,
    SPD_APPR   = 2'b10,
    SPD_COMP   = 2'b11
  } osp_spd_e;

  typedef struct packed {
    logic     run;
    logic     dir;
    osp_spd_e speed;
    logic     torque_lim;
    logic     dev_reset;
  } osp_drive_s;

  typedef struct packed {
    logic origin_def;
    logic at_origin;
    logic busy;
    logic error;
  } osp_stat_s;
endpackage

// File: bench/osp_axis_sva.sv
// Checker for one origin search and preset axis, seeing its ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module osp_axis_sva
  import osp_pkg::*;
#(
  parameter int DWELL_CYCLES = DWELL_CYC,
  parameter int DEVR_CYCLES  = DEVR_CYC
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  input  wire logic [AW-1:0]      i_addr,
  input  wire logic [DW-1:0]      i_wdata,
  input  wire logic               i_we,
  input  wire logic               i_re,
  input  wire logic [DW-1:0]      o_rdata,
  input  wire logic               i_prox,
  input  wire logic               i_origin,
  input  wire logic               i_intr,
  input  wire logic signed [15:0] i_pos_delta,
  input  wire logic               i_drive_busy,
  input  wire logic               i_stop,
  input  wire logic               i_tool_mode,
  input  wire logic               i_tool_other_busy,
  input  wire osp_drive_s         o_drive,
  input  wire logic               o_start,
  input  wire osp_stat_s          o_stat
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] dw_cnt_r;
  wire         cmd_w  = i_we && i_addr == REG_CMD;
  wire         pre_w  = cmd_w && i_wdata == (32'h1 << CMD_PRESET);
  wire         home_w = cmd_w && i_wdata == (32'h1 << CMD_HOME);
  // Cycles since the deviation reset ended; saturates so it never wraps
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) dw_cnt_r <= 32'h0;
    else if ($fell(o_drive.dev_reset)) dw_cnt_r <= 32'h1;
    else if (dw_cnt_r != 32'h0 && dw_cnt_r < 32'hffff) dw_cnt_r <= dw_cnt_r + 32'h1;
  end
  trq_run_a: assert property (
    o_drive.torque_lim |-> o_drive.run) else $error("torque limit without motion");
  atorg_def_a: assert property (
    o_stat.at_origin |-> o_stat.origin_def) else $error("at origin while undefined");
  comp_undef_a: assert property (
    o_drive.run && o_drive.speed == SPD_COMP |-> !o_stat.origin_def)
    else $error("origin defined during compensation");
  dwell_wait_a: assert property (
    o_drive.speed == SPD_COMP && dw_cnt_r != 32'h0 |-> dw_cnt_r >= 32'(DWELL_CYCLES - 1))
    else $error("compensation began too early");
  pbusy_err_a: assert property (
    pre_w && i_drive_busy && o_stat.busy && !o_stat.error |=> o_stat.error)
    else $error("preset while busy gave no error");
  pre_def_a: assert property (
    pre_w && !o_stat.busy && !i_drive_busy && !o_stat.error |=> o_stat.origin_def || o_stat.error)
    else $error("preset left origin undefined");
  perr_keep_a: assert property (
    pre_w && o_stat.error |=> $stable(o_stat.origin_def) && o_stat.error)
    else $error("preset acted during error");
  tool_rej_a: assert property (
    home_w && i_tool_mode && i_tool_other_busy && !o_stat.error && !o_stat.busy |=> o_stat.error)
    else $error("tool mode command not refused");
endmodule
bind osp_axis osp_axis_sva #(.DWELL_CYCLES(DWELL_CYCLES), .DEVR_CYCLES(DEVR_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
  .i_re(i_re), .o_rdata(o_rdata), .i_prox(i_prox), .i_origin(i_origin), .i_intr(i_intr),
  .i_pos_delta(i_pos_delta), .i_drive_busy(i_drive_busy), .i_stop(i_stop),
  .i_tool_mode(i_tool_mode), .i_tool_other_busy(i_tool_other_busy), .o_drive(o_drive),
  .o_start(o_start), .o_stat(o_stat));
`default_nettype wire

// File: bench/osp_drv_model.sv
// Servo drive stand-in: turns drive commands into position feedback and busy.
// Assumes registered drive commands on the system clock.
`timescale 1ns/100ps
`default_nettype none
module osp_drv_model
  import osp_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire osp_drive_s    i_drive,
  input  wire logic          i_start,
  input  wire logic          i_hold,
  output logic signed [15:0] o_pos_delta,
  output logic               o_busy
);
  logic        [2:0]  busy_cnt_r;
  logic signed [15:0] step_w;
  // Step size follows the speed code only; the torque limit flag is not modelled
  assign step_w = i_drive.speed == SPD_SEARCH ? 16'sh4
                : i_drive.speed == SPD_COMP   ? 16'sh2 : 16'sh1;
  assign o_pos_delta = !i_drive.run ? 16'sh0 : i_drive.dir ? step_w : -step_w;
  // A positioning start keeps the drive busy briefly; i_hold stalls it at will
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) busy_cnt_r <= 3'h0;
    else if (i_start) busy_cnt_r <= 3'h4;
    else if (busy_cnt_r != 3'h0) busy_cnt_r <= busy_cnt_r - 3'h1;
  end
  assign o_busy = i_hold || busy_cnt_r != 3'h0;
endmodule
`default_nettype wire

// File: bench/osp_axis_bench.sv
// Self-checking bench for the origin search and preset axis.
// Assumes the drive model beside the design and shortened dwell counts.
`timescale 1ns/100ps
`default_nettype none
module osp_axis_bench;
  import osp_pkg::*;
  logic               clk, rst_n, we, re, prox, orig, intr, hold, tmode, tbusy, start, dbusy;
  logic [AW-1:0]      addr;
  logic [DW-1:0]      wdata, rdata;
  logic signed [15:0] delta;
  osp_drive_s         drv;
  osp_stat_s          st;
  int                 n_mismatch, num_checks, cyc;
  osp_axis #(.DWELL_CYCLES(20), .DEVR_CYCLES(5)) u_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .i_prox(prox),
    .i_origin(orig), .i_intr(intr), .i_pos_delta(delta), .i_drive_busy(dbusy), .i_stop(1'b0),
    .i_tool_mode(tmode), .i_tool_other_busy(tbusy), .o_drive(drv), .o_start(start), .o_stat(st));
  osp_drv_model u_drv (.i_clk_sys(clk), .i_rst_n(rst_n), .i_drive(drv), .i_start(start),
    .i_hold(hold), .o_pos_delta(delta), .o_busy(dbusy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic chkr(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic cmd(input int b);
    wr(REG_CMD, 32'h1 << b);
    tick(3);
  endtask
  // Pin pulses last past the input filter
  task automatic origin_hit();
    @(posedge clk);
    orig <= 1'b1;
    repeat (8) @(posedge clk);
    orig <= 1'b0;
    #1;
    for (int i = 0; i < 300 && st.busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(st.busy), 32'h0);
  endtask
  task automatic t_basic();
    chkr(REG_CTRL, CTRL_RST);
    chkr(4'hf, 32'h0);
    wr(REG_OFFS, 32'h0);
    wr(REG_CTRL, 32'h0e);
    cmd(CMD_HOME);
    chkr(REG_STAT, 32'h3);
    wr(REG_OFFS, 32'h5);
    cmd(CMD_HOME);
    chkr(REG_POS, 32'h5);
    chkr(REG_STAT, 32'h1);
    $display("test basic done");
  endtask
  task automatic t_home();
    logic [DW-1:0] p0, d;
    wr(REG_OFFS, 32'h20);
    wr(REG_CTRL, 32'h1d);
    cmd(CMD_HOME);
    chk(32'(drv), 32'h3a);
    chkr(REG_STAT, 32'h14);
    rd(REG_POS, p0);
    origin_hit();
    chkr(REG_POS, 32'h20);
    rd(REG_LATCH, d);
    chk(32'(d - p0 < 32'h10), 32'h1);
    wr(REG_CTRL, 32'h1c);
    @(posedge clk);
    prox <= 1'b1;
    tick(6);
    cmd(CMD_HOME);
    chk(32'(drv), 32'h24);
    @(posedge clk);
    prox <= 1'b0;
    tick(8);
    chk(32'(drv) & 32'h3c, 32'h38);
    origin_hit();
    chkr(REG_STAT, 32'h1);
    cmd(CMD_HOME);
    chk(32'(drv) & 32'h2e, 32'h24);
    @(posedge clk);
    prox <= 1'b1;
    tick(8);
    chk(32'(drv), 32'h3a);
    @(posedge clk);
    prox <= 1'b0;
    origin_hit();
    chkr(REG_POS, 32'h20);
    $display("test home done");
  endtask
  task automatic t_comp();
    int ndev, ncmp;
    wr(REG_COMP, 32'h6);
    wr(REG_CTRL, 32'h8d);
    cmd(CMD_HOME);
    @(posedge clk);
    orig <= 1'b1;
    repeat (8) @(posedge clk);
    orig <= 1'b0;
    #1;
    for (int i = 0; i < 300 && st.busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
      if (drv.dev_reset === 1'b1) ndev++;
      if (drv.run === 1'b1 && drv.speed === SPD_COMP) ncmp++;
    end
    chk(32'(st.busy), 32'h0);
    chk(32'(ndev != 0 && ncmp != 0), 32'h1);
    chkr(REG_POS, 32'h20);
    chkr(REG_STAT, 32'h1);
    wr(REG_COMP, 32'h0);
    $display("test compensation done");
  endtask
  task automatic t_preset();
    wr(REG_CTRL, 32'h0d);
    wr(REG_PVAL, 32'h8000_1234);
    cmd(CMD_PRESET);
    chkr(REG_POS, 32'h8000_1234);
    wr(REG_PVAL, 32'h0);
    cmd(CMD_PRESET);
    chkr(REG_STAT, 32'h3);
    wr(REG_CTRL, 32'h4d);
    wr(REG_ROTMAX, 32'h64);
    wr(REG_PVAL, 32'h65);
    cmd(CMD_PRESET);
    chkr(REG_ERR, 32'h2);
    wr(REG_PVAL, 32'h10);
    cmd(CMD_PRESET);
    chkr(REG_POS, 32'h0);
    cmd(CMD_ERRCLR);
    wr(REG_CTRL, 32'h0d);
    @(posedge clk);
    hold <= 1'b1;
    cmd(CMD_PRESET);
    chkr(REG_ERR, 32'h1);
    @(posedge clk);
    hold <= 1'b0;
    cmd(CMD_ERRCLR);
    @(posedge clk);
    tmode <= 1'b1;
    tbusy <= 1'b1;
    cmd(CMD_HOME);
    chkr(REG_ERR, 32'h5);
    @(posedge clk);
    tmode <= 1'b0;
    tbusy <= 1'b0;
    cmd(CMD_ERRCLR);
    wr(REG_MASK, 32'h2);
    wr(REG_DECEL, 32'ha);
    wr(REG_CTRL, 32'h09);
    cmd(CMD_HOME);
    chkr(REG_ERR, 32'h3);
    cmd(CMD_ERRCLR);
    wr(REG_MASK, 32'hb);
    cmd(CMD_HOME);
    chkr(REG_ERR, 32'h4);
    cmd(CMD_ERRCLR);
    $display("test preset done");
  endtask
  task automatic t_clear();
    wr(REG_CTRL, 32'h2e);
    for (int b = CMD_DIRECT; b <= CMD_JOG; b++) begin
      wr(REG_PVAL, 32'h50);
      cmd(CMD_PRESET);
      wr(REG_CMD, 32'h1 << b);
      #1;
      chk(32'(start), 32'h1);
      tick(9);
      chkr(REG_POS, b < CMD_CHAIN ? 32'h0 : 32'h50);
      chkr(REG_STAT, b < CMD_CHAIN ? 32'h0 : 32'h1);
    end
    cmd(CMD_PRESET);
    @(posedge clk);
    intr <= 1'b1;
    repeat (8) @(posedge clk);
    intr <= 1'b0;
    tick(8);
    chkr(REG_POS, 32'h0);
    cmd(CMD_HOME);
    chkr(REG_POS, 32'h20);
    $display("test clear done");
  endtask
  initial begin
    {rst_n, we, re, prox, orig, intr, hold, tmode, tbusy} = 9'h0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_home();
    t_comp();
    t_preset();
    t_clear();
    print_verdict();
  end
endmodule
`default_nettype wire
